/* File: logic/mac_frac_unsigned_datapath.sv */
/*
  Multiply-accumulate datapath for the signed fractional and unsigned integer
  formats, with its registers reached over APB: status and mode, accumulator,
  two source registers and a command register that starts one operation.
  Assumes an APB master on ref_clk; the signed integer format is not handled.
*/
// Functional notes
// RL1: Mode codes 1 and 3 select fractional, code 2 unsigned arithmetic.
// RL2: Saturation on with sticky overflow set skips the operation; else clear overflow.
// RL3: Fractional word operand is the selected half in bits 31:16, zeros below.
// RL4: Fractional product is the 64-bit product shifted left one bit.
// RL5: With rounding on, increment upper half when lower half exceeds 0x8000_0000.
// RL6: On an exact tie, increment upper half only if product bit 32 is one.
// RL7: Fractional mode adds upper product half to accumulator, or subtracts it.
// RL8: Fractional overflow sets flag; saturation picks most positive or most negative.
// RL9: Unsigned word operands are zero-extended halves; longword uses whole registers.
// RL10: Unsigned product overflow when upper half nonzero; saturate zero or all ones.
// RL11: Unsigned left scale overflows on product bit 31, else shifts left inserting zero.
// RL12: Unsigned right scale shifts bits 31:1 down, zero into bit 31.
// RL13: Scale code 0 none, 1 left, 3 right, 2 reserved meaning none.
// RL14: Unsigned combine only while overflow clear; overflow saturates zero or all ones.
// RL15: Result goes to accumulator; negative is bit 31, zero when all bits zero.
// RL16: Unsigned multiply-subtract saturates to zero rather than all ones.
// RL17: Product scale is ignored in fractional mode.
// RL18: Overflow flag is sticky until accumulator or status register is written; the code reloads it on each unskipped fractional or unsigned operation.
// RL19: Signed/unsigned and fractional/integer status bits together choose the format.
// RL20: Overflow is signed overflow in fractional mode, carry or borrow in unsigned.
// RL21: One operation per command, finished before any further register access.
`timescale 1ns/1ns
module mac_frac_unsigned_datapath
  import mac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] acc_value,
  output logic flag_n,
  output logic flag_z,
  output logic flag_v,
  output logic op_done
);

  // Status, mode and command fields.
  logic saturate_on_overflow;
  logic unsigned_sel;
  logic fractional_sel;
  logic round_en;
  logic multiply_subtract;
  logic longword;
  logic x_half_select;
  logic y_half_select;
  logic [1:0] product_scale;
  logic [31:0] src_x;
  logic [31:0] src_y;
  mac_state_t state;

  // Next values.
  logic next_saturate_on_overflow;
  logic next_unsigned_sel;
  logic next_fractional_sel;
  logic next_round_en;
  logic next_multiply_subtract;
  logic next_longword;
  logic next_x_half_select;
  logic next_y_half_select;
  logic [1:0] next_product_scale;
  logic [31:0] next_src_x;
  logic [31:0] next_src_y;
  logic [31:0] next_acc_value;
  logic next_flag_n;
  logic next_flag_z;
  logic next_flag_v;
  logic next_op_done;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  mac_state_t next_state;

  // Datapath intermediates.
  logic [1:0] mode_code;
  logic frac_mode;
  logic uns_mode;
  logic [31:0] operand_x;
  logic [31:0] operand_y;
  logic [63:0] product;
  logic [63:0] frac_prod;
  logic [31:0] frac_hi;
  logic [31:0] uns_lo;
  logic [31:0] uns_sat;
  logic [32:0] uns_sum;
  logic [31:0] result;
  logic overflow;

  // Bus decode.
  logic access;
  logic addr_hit;
  logic commit_write;
  logic [31:0] status_word;
  logic [31:0] cmd_word;

  // The two format bits form one code that selects the arithmetic.
  assign mode_code = {unsigned_sel, fractional_sel}; // RL19
  assign frac_mode = (mode_code == MODE_FRAC_A) || (mode_code == MODE_FRAC_B); // RL1
  assign uns_mode = (mode_code == MODE_UNSIGNED); // RL1

  // Operands are chosen and registered one cycle after the command.
  mac_operand_select u_operand_select (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .rx(src_x),
    .ry(src_y),
    .longword(longword),
    .x_half_select(x_half_select),
    .y_half_select(y_half_select),
    .frac_mode(frac_mode),
    .operand_x(operand_x),
    .operand_y(operand_y)
  );

  // The product is registered one cycle after the operands.
  mac_multiplier u_multiplier (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .operand_x(operand_x),
    .operand_y(operand_y),
    .signed_mul(frac_mode),
    .product(product)
  );

  // Result of the current operation, read only in the accumulate state.
  always_comb begin
    frac_prod = {product[62:0], 1'b0}; // RL4
    frac_hi = frac_prod[63:32];
    uns_lo = product[31:0];
    uns_sat = multiply_subtract ? ZERO32 : ALL_ONES; // RL16
    uns_sum = {1'b0, ZERO32};
    result = acc_value;
    overflow = 1'b0;
    if (frac_mode) begin
      // Convergent rounding: above half rounds up, a tie rounds to even.
      if (round_en) begin
        if (frac_prod[31:0] > ROUND_TIE) begin
          frac_hi = frac_hi + ONE32; // RL5
        end else if ((frac_prod[31:0] == ROUND_TIE) && frac_prod[32]) begin
          frac_hi = frac_hi + ONE32; // RL6
        end
      end
      // No scaling here: the scale field is not looked at in this format.
      if (multiply_subtract) begin
        result = acc_value - frac_hi; // RL7 RL17
        overflow = (acc_value[31] != frac_hi[31]) && (result[31] != acc_value[31]); // RL20
      end else begin
        result = acc_value + frac_hi; // RL7 RL17
        overflow = (acc_value[31] == frac_hi[31]) && (result[31] != acc_value[31]); // RL20
      end
      if (overflow && saturate_on_overflow) begin
        result = result[31] ? SAT_POS : SAT_NEG; // RL8
      end
    end else if (uns_mode) begin
      // Product too wide for 32 bits.
      if (product[63:32] != ZERO32) begin
        overflow = 1'b1; // RL10
        if (saturate_on_overflow) begin
          result = uns_sat; // RL10 RL16
        end
      end
      // Optional one-bit scale of the low product word.
      case (product_scale)
        SCALE_LEFT: begin
          if (product[31]) begin
            overflow = 1'b1; // RL11
            if (saturate_on_overflow) begin
              result = uns_sat; // RL11
            end
          end else begin
            uns_lo = {product[30:0], 1'b0}; // RL11
          end
        end
        SCALE_RIGHT: begin
          uns_lo = {1'b0, product[31:1]}; // RL12
        end
        default: begin
          uns_lo = product[31:0]; // RL13
        end
      endcase
      // Combine only when nothing has overflowed yet; carry or borrow is overflow.
      if (!overflow) begin
        if (multiply_subtract) begin
          uns_sum = {1'b0, acc_value} - {1'b0, uns_lo}; // RL14
        end else begin
          uns_sum = {1'b0, acc_value} + {1'b0, uns_lo}; // RL14
        end
        result = uns_sum[31:0];
        if (uns_sum[32]) begin
          overflow = 1'b1; // RL20 RL14
          if (saturate_on_overflow) begin
            result = uns_sat; // RL14 RL16
          end
        end
      end
    end
  end

  // Bus decode and read data; access is granted only while idle.
  always_comb begin
    access = psel && penable;
    commit_write = access && pready && pwrite && !pslverr;
    status_word = ZERO32;
    status_word[STS_SAT_BIT] = saturate_on_overflow;
    status_word[STS_SU_BIT] = unsigned_sel;
    status_word[STS_FI_BIT] = fractional_sel;
    status_word[STS_RND_BIT] = round_en;
    status_word[STS_N_BIT] = flag_n;
    status_word[STS_Z_BIT] = flag_z;
    status_word[STS_V_BIT] = flag_v;
    cmd_word = ZERO32;
    cmd_word[CMD_MSUB_BIT] = multiply_subtract;
    cmd_word[CMD_LONG_BIT] = longword;
    cmd_word[CMD_XHALF_BIT] = x_half_select;
    cmd_word[CMD_YHALF_BIT] = y_half_select;
    cmd_word[CMD_SCALE_LSB +: 2] = product_scale;
    addr_hit = 1'b1;
    case (paddr)
      OFS_STATUS: next_prdata = status_word;
      OFS_ACC: next_prdata = acc_value;
      OFS_OPX: next_prdata = src_x;
      OFS_OPY: next_prdata = src_y;
      OFS_CMD: next_prdata = cmd_word;
      default: begin
        next_prdata = ZERO32;
        addr_hit = 1'b0;
      end
    endcase
    if (!(access && !pready && (state == ST_IDLE))) begin
      next_prdata = prdata;
    end
  end

  // Next values of the bus answer, the registers and the sequencer.
  always_comb begin
    next_pready = access && !pready && (state == ST_IDLE); // RL21
    next_pslverr = next_pready ? !addr_hit : 1'b0;
    next_saturate_on_overflow = saturate_on_overflow;
    next_unsigned_sel = unsigned_sel;
    next_fractional_sel = fractional_sel;
    next_round_en = round_en;
    next_multiply_subtract = multiply_subtract;
    next_longword = longword;
    next_x_half_select = x_half_select;
    next_y_half_select = y_half_select;
    next_product_scale = product_scale;
    next_src_x = src_x;
    next_src_y = src_y;
    next_acc_value = acc_value;
    next_flag_n = flag_n;
    next_flag_z = flag_z;
    next_flag_v = flag_v;
    next_op_done = 1'b0;
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (commit_write) begin
          case (paddr)
            OFS_STATUS: begin
              next_saturate_on_overflow = pwdata[STS_SAT_BIT];
              next_unsigned_sel = pwdata[STS_SU_BIT];
              next_fractional_sel = pwdata[STS_FI_BIT];
              next_round_en = pwdata[STS_RND_BIT];
              next_flag_n = pwdata[STS_N_BIT];
              next_flag_z = pwdata[STS_Z_BIT];
              next_flag_v = pwdata[STS_V_BIT]; // RL18
            end
            OFS_ACC: begin
              next_acc_value = pwdata;
              next_flag_v = 1'b0; // RL18
            end
            OFS_OPX: next_src_x = pwdata;
            OFS_OPY: next_src_y = pwdata;
            OFS_CMD: begin
              next_multiply_subtract = pwdata[CMD_MSUB_BIT];
              next_longword = pwdata[CMD_LONG_BIT];
              next_x_half_select = pwdata[CMD_XHALF_BIT];
              next_y_half_select = pwdata[CMD_YHALF_BIT];
              next_product_scale = pwdata[CMD_SCALE_LSB +: 2];
              next_state = ST_SELECT; // RL21
            end
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_SELECT: next_state = ST_MULTIPLY;
      ST_MULTIPLY: next_state = ST_ACCUMULATE;
      ST_ACCUMULATE: begin
        next_state = ST_IDLE;
        next_op_done = 1'b1;
        // Saturating with overflow already flagged leaves the accumulator and all flags as they are.
        if ((frac_mode || uns_mode) && !(saturate_on_overflow && flag_v)) begin // RL2
          next_acc_value = result; // RL15
          next_flag_v = overflow; // RL2 RL18
          next_flag_n = result[31]; // RL15
          next_flag_z = (result == ZERO32); // RL15
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // All state of the block.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      prdata <= RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
      saturate_on_overflow <= 1'b0;
      unsigned_sel <= 1'b0;
      fractional_sel <= 1'b0;
      round_en <= 1'b0;
      multiply_subtract <= 1'b0;
      longword <= 1'b0;
      x_half_select <= 1'b0;
      y_half_select <= 1'b0;
      product_scale <= RST_CODE;
      src_x <= RST_WORD;
      src_y <= RST_WORD;
      acc_value <= RST_WORD;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      flag_v <= 1'b0;
      op_done <= 1'b0;
    end else begin
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      saturate_on_overflow <= next_saturate_on_overflow;
      unsigned_sel <= next_unsigned_sel;
      fractional_sel <= next_fractional_sel;
      round_en <= next_round_en;
      multiply_subtract <= next_multiply_subtract;
      longword <= next_longword;
      x_half_select <= next_x_half_select;
      y_half_select <= next_y_half_select;
      product_scale <= next_product_scale;
      src_x <= next_src_x;
      src_y <= next_src_y;
      acc_value <= next_acc_value;
      flag_n <= next_flag_n;
      flag_z <= next_flag_z;
      flag_v <= next_flag_v;
      op_done <= next_op_done;
    end
  end

endmodule : mac_frac_unsigned_datapath

/* File: logic/mac_multiplier.sv */
/*
  Registered 32x32 multiplier giving a 64-bit product, signed for the
  fractional format and unsigned otherwise.
  Assumes operands are held stable for the cycle before the product is used.
*/
`timescale 1ns/1ns
module mac_multiplier
  import mac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [31:0] operand_x,
  input wire logic [31:0] operand_y,
  input wire logic signed_mul,
  output logic [63:0] product
);

  logic signed [32:0] ext_x;
  logic signed [32:0] ext_y;
  logic signed [65:0] full;
  logic [63:0] next_product;

  // One extra bit carries the sign or a zero, so one multiplier serves both.
  always_comb begin
    ext_x = $signed({signed_mul & operand_x[31], operand_x});
    ext_y = $signed({signed_mul & operand_y[31], operand_y});
    full = ext_x * ext_y; // RL4
    next_product = full[63:0];
  end

  // Product register.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      product <= RST_PRODUCT;
    end else begin
      product <= next_product;
    end
  end

endmodule : mac_multiplier

/* File: logic/mac_operand_select.sv */
/*
  Operand selection stage: picks register halves or whole registers and
  places them for fractional or unsigned arithmetic, then registers them.
  Assumes its inputs stay stable while an operation is in flight.
*/
`timescale 1ns/1ns
module mac_operand_select
  import mac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [31:0] rx,
  input wire logic [31:0] ry,
  input wire logic longword,
  input wire logic x_half_select,
  input wire logic y_half_select,
  input wire logic frac_mode,
  output logic [31:0] operand_x,
  output logic [31:0] operand_y
);

  logic [15:0] half_x;
  logic [15:0] half_y;
  logic [31:0] next_operand_x;
  logic [31:0] next_operand_y;

  // Upper half when the select bit is one; fractional halves sit high.
  always_comb begin
    half_x = x_half_select ? rx[31:16] : rx[15:0];
    half_y = y_half_select ? ry[31:16] : ry[15:0];
    if (longword) begin
      next_operand_x = rx; // RL9
      next_operand_y = ry;
    end else if (frac_mode) begin
      next_operand_x = {half_x, HALF_PAD}; // RL3
      next_operand_y = {half_y, HALF_PAD}; // RL3
    end else begin
      next_operand_x = {HALF_PAD, half_x}; // RL9
      next_operand_y = {HALF_PAD, half_y}; // RL9
    end
  end

  // Operand registers.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      operand_x <= RST_WORD;
      operand_y <= RST_WORD;
    end else begin
      operand_x <= next_operand_x;
      operand_y <= next_operand_y;
    end
  end

endmodule : mac_operand_select

/* File: logic/mac_pkg.sv */
/*
  Shared constants for the multiply-accumulate datapath: register offsets,
  field positions, reset values, mode and scale codes, saturation values and
  the sequencer states.
  Assumes a 12-bit APB byte address with 32-bit data.
*/
package mac_pkg;

  // Register byte offsets on the APB bus.
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_OPX = 12'h008;
  localparam logic [11:0] OFS_OPY = 12'h00C;
  localparam logic [11:0] OFS_CMD = 12'h010;

  // Field positions in mac_status_reg.
  localparam int unsigned STS_SAT_BIT = 7;
  localparam int unsigned STS_SU_BIT = 6;
  localparam int unsigned STS_FI_BIT = 5;
  localparam int unsigned STS_RND_BIT = 4;
  localparam int unsigned STS_N_BIT = 3;
  localparam int unsigned STS_Z_BIT = 2;
  localparam int unsigned STS_V_BIT = 1;

  // Field positions in the command register.
  localparam int unsigned CMD_MSUB_BIT = 0;
  localparam int unsigned CMD_LONG_BIT = 1;
  localparam int unsigned CMD_XHALF_BIT = 2;
  localparam int unsigned CMD_YHALF_BIT = 3;
  localparam int unsigned CMD_SCALE_LSB = 4;

  // Operand format codes, taken from the signed/unsigned and fractional bits.
  localparam logic [1:0] MODE_SIGNED_INT = 2'h0;
  localparam logic [1:0] MODE_FRAC_A = 2'h1;
  localparam logic [1:0] MODE_UNSIGNED = 2'h2;
  localparam logic [1:0] MODE_FRAC_B = 2'h3;

  // Product scale codes.
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_LEFT = 2'h1;
  localparam logic [1:0] SCALE_RSVD = 2'h2;
  localparam logic [1:0] SCALE_RIGHT = 2'h3;

  // Saturation, rounding and padding values.
  localparam logic [31:0] SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG = 32'h8000_0000;
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [31:0] ROUND_TIE = 32'h8000_0000;
  localparam logic [31:0] ONE32 = 32'h0000_0001;
  localparam logic [15:0] HALF_PAD = 16'h0000;

  // Values after reset.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [63:0] RST_PRODUCT = 64'h0000_0000_0000_0000;
  localparam logic [1:0] RST_CODE = 2'h0;

  // Sequencer of one multiply-accumulate.
  typedef enum {ST_IDLE, ST_SELECT, ST_MULTIPLY, ST_ACCUMULATE} mac_state_t;

endpackage : mac_pkg

/* File: verif/mac_core_model.sv */
/*
  Core-side model that issues register transfers to the datapath as an APB master.
  Assumes a running ref_clk and one calling process at a time.
*/
`timescale 1ns/1ns
module mac_core_model
  import mac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  // Bus idle from time zero so reset sees no request.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = OFS_STATUS;
    pwdata = ZERO32;
  end

  // Setup cycle, then access held until pready is sampled; released lines are scrambled.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : mac_core_model

/* File: verif/mac_datapath_sva.sv */
/*
  Checker for the multiply-accumulate datapath, bound to its top module.
  Assumes an APB master that holds each request until pready is seen high.
*/
`timescale 1ns/1ns
module mac_datapath_sva
  import mac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic [31:0] acc_value,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_v,
  input wire logic op_done
);
  logic wr_cmd;
  logic wr_acc;
  logic wr_sts;
  logic inflight;
  logic next_inflight;

  // Completed register writes, decoded by target.
  assign wr_cmd = psel && penable && pready && pwrite && (paddr == OFS_CMD);
  assign wr_acc = psel && penable && pready && pwrite && (paddr == OFS_ACC);
  assign wr_sts = psel && penable && pready && pwrite && (paddr == OFS_STATUS);

  // Marks an operation from its command write until its commit.
  always_comb begin
    next_inflight = wr_cmd ? 1'b1 : (op_done ? 1'b0 : inflight);
  end

  // Registers the in-flight marker.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      inflight <= 1'b0;
    end else begin
      inflight <= next_inflight;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // The bus stalls while the operation runs, then the result commits.
  sequence s_stall;
    (!pready) [*3];
  endsequence
  sequence s_commit;
    ##[1:6] op_done;
  endsequence

  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("op_done held for more than one cycle");
  a_cmd_commits: assert property (wr_cmd |-> s_commit)
    else $error("command write not followed by a commit");
  a_bus_stalls: assert property (wr_cmd |=> s_stall)
    else $error("bus answered while an operation ran");
  a_zero_flag: assert property (op_done |-> flag_z == (acc_value == ZERO32))
    else $error("zero flag disagrees with accumulator");
  a_neg_flag: assert property (op_done |-> flag_n == acc_value[31])
    else $error("negative flag disagrees with accumulator bit 31");
  a_acc_cause: assert property (!$stable(acc_value) |-> op_done || $past(wr_acc))
    else $error("accumulator changed without commit or write");
  a_flag_cause: assert property (($changed(flag_n) || $changed(flag_z))
    |-> op_done || $past(wr_sts) || $past(wr_acc))
    else $error("negative or zero flag changed without cause");
  a_acc_clears_v: assert property (wr_acc |=> !flag_v)
    else $error("accumulator write left overflow set");
  a_v_sticky: assert property ($fell(flag_v)
    |-> op_done || inflight || $past(wr_sts) || $past(wr_acc))
    else $error("overflow flag cleared without cause");
endmodule : mac_datapath_sva

bind mac_frac_unsigned_datapath mac_datapath_sva u_sva (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pready(pready),
  .acc_value(acc_value),
  .flag_n(flag_n),
  .flag_z(flag_z),
  .flag_v(flag_v),
  .op_done(op_done)
);

/* File: verif/mac_frac_unsigned_datapath_bench.sv */
/*
  Self-checking bench for the multiply-accumulate datapath.
  Assumes the core model drives the APB side and the checker is bound.
*/
`timescale 1ns/1ns
module mac_frac_unsigned_datapath_bench;
  import mac_pkg::*;
  logic ref_clk;
  logic nrst;
  logic psel, penable, pwrite, pready, pslverr, flag_n, flag_z, flag_v, op_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, acc_value;
  int err_count;
  int checked;

  // Design and the core that feeds it.
  mac_frac_unsigned_datapath u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc_value(acc_value), .flag_n(flag_n),
    .flag_z(flag_z), .flag_v(flag_v), .op_done(op_done));
  mac_core_model u_core (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // Clock at 100 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compares and counts.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // Register write and read through the core.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_core.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic e);
    u_core.xfer(1'b0, a, ZERO32, q, e);
  endtask : rd

  // Loads state, issues one command and checks accumulator and flags.
  task automatic run_op(input logic [7:0] sts, input logic [31:0] acc, input logic [31:0] x,
                        input logic [31:0] y, input logic [7:0] cmd,
                        input logic [31:0] want_acc, input logic [7:0] want_sts);
    logic [31:0] q;
    logic e;
    wr(OFS_ACC, acc);
    wr(OFS_STATUS, {24'h00_0000, sts});
    wr(OFS_OPX, x);
    wr(OFS_OPY, y);
    wr(OFS_CMD, {24'h00_0000, cmd});
    rd(OFS_ACC, q, e);
    check(q, want_acc);
    check(acc_value, want_acc);
    rd(OFS_STATUS, q, e);
    check(q, {24'h00_0000, want_sts});
    check(32'({flag_n, flag_z, flag_v}), 32'(want_sts[3:1]));
  endtask : run_op

  // Reset contents, refused address and direct loads of the overflow flag.
  task automatic t_bus();
    logic [31:0] q;
    logic e;
    rd(OFS_ACC, q, e);
    check(q, ZERO32);
    rd(12'h014, q, e);
    check(q, ZERO32);
    check(32'(e), ONE32);
    wr(OFS_STATUS, 32'h0000_0022);
    rd(OFS_STATUS, q, e);
    check(q, 32'h0000_0022);
    wr(OFS_ACC, ZERO32);
    rd(OFS_STATUS, q, e);
    check(q, 32'h0000_0020);
  endtask : t_bus

  // Fractional operand placement, product alignment and rounding.
  task automatic t_frac();
    run_op(8'h20, ZERO32, 32'h4000_1234, 32'h5678_4000, 8'h04, 32'h2000_0000, 8'h20);
    run_op(8'h60, ZERO32, 32'h4000_0000, 32'h4000_0000, 8'h03, 32'hE000_0000, 8'h68);
    run_op(8'h30, ZERO32, 32'h4000_0000, 32'h0000_0003, 8'h02, 32'h0000_0002, 8'h30);
    run_op(8'h30, ZERO32, 32'h4000_0000, ONE32, 8'h02, ZERO32, 8'h34);
    run_op(8'h30, ZERO32, 32'h6000_0000, ONE32, 8'h02, ONE32, 8'h30);
    run_op(8'h20, ZERO32, 32'h6000_0000, ONE32, 8'h02, ZERO32, 8'h24);
    run_op(8'h20, ZERO32, 32'h4000_0000, 32'h4000_0000, 8'h32, 32'h2000_0000, 8'h20);
  endtask : t_frac

  // Fractional overflow, saturation and skipping on sticky overflow.
  task automatic t_frac_sat();
    run_op(8'hA0, SAT_POS, 32'h4000_0000, 32'h4000_0000, 8'h02, SAT_POS, 8'hA2);
    run_op(8'hA2, 32'h1234_5678, ONE32, ONE32, 8'h02, 32'h1234_5678, 8'hA2);
    run_op(8'hA0, SAT_NEG, 32'h4000_0000, 32'h4000_0000, 8'h03, SAT_NEG, 8'hAA);
    run_op(8'h20, SAT_POS, 32'h4000_0000, 32'h4000_0000, 8'h02, 32'h9FFF_FFFF, 8'h2A);
    run_op(8'h22, ZERO32, 32'h4000_0000, 32'h4000_0000, 8'h02, 32'h2000_0000, 8'h20);
  endtask : t_frac_sat

  // Unsigned operands, product and accumulation overflow.
  task automatic t_unsigned();
    run_op(8'h40, 32'h0000_0005, 32'hFFFF_0002, 32'h0003_FFFF, 8'h08, 32'h0000_000B, 8'h40);
    run_op(8'h40, ZERO32, 32'h0001_0000, 32'h0000_FFFF, 8'h02, 32'hFFFF_0000, 8'h48);
    run_op(8'hC0, 32'h0000_0005, 32'h0001_0000, 32'h0001_0000, 8'h02, ALL_ONES, 8'hCA);
    run_op(8'hC0, 32'h0000_0005, 32'h0001_0000, 32'h0001_0000, 8'h03, ZERO32, 8'hC6);
    run_op(8'h40, 32'h0000_0005, 32'h0001_0000, 32'h0001_0000, 8'h02, 32'h0000_0005, 8'h42);
    run_op(8'hC0, ALL_ONES, ONE32, ONE32, 8'h02, ALL_ONES, 8'hCA);
    run_op(8'hC0, ZERO32, ONE32, ONE32, 8'h03, ZERO32, 8'hC6);
    run_op(8'h00, 32'h0000_0005, ONE32, ONE32, 8'h02, 32'h0000_0005, 8'h00);
  endtask : t_unsigned

  // Every scale code, a right shift of bit 31 and a left-shift overflow.
  task automatic t_scale();
    logic [31:0] want [4];
    want = '{32'h0000_0003, 32'h0000_0006, 32'h0000_0003, ONE32};
    for (int i = 0; i < 4; i++) begin
      run_op(8'h40, ZERO32, 32'h0000_0003, ONE32, {2'b00, 2'(i), 4'h2}, want[i], 8'h40);
    end
    run_op(8'h40, ZERO32, 32'h8000_0002, ONE32, 8'h32, 32'h4000_0001, 8'h40);
    run_op(8'hC0, 32'h0000_0005, 32'h8000_0000, ONE32, 8'h12, ALL_ONES, 8'hCA);
    run_op(8'hC0, 32'h0000_0005, 32'h8000_0000, ONE32, 8'h13, ZERO32, 8'hC6);
  endtask : t_scale

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Reset, then the scenarios in turn.
  initial begin
    nrst = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_bus();
    t_frac();
    t_frac_sat();
    t_unsigned();
    t_scale();
    conclude();
  end

  // Cuts a hang short well beyond the expected run of under a thousand cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
endmodule : mac_frac_unsigned_datapath_bench
